// [rtl/bcp_pkg.sv]
// Package: pin map, register fields, timing and request types for the block-check controller
package bcp_pkg;
	// Clock and pin timing
	localparam int CLK_MHZ      = 40;
	localparam int T_SETUP_NS   = 50;
	localparam int T_STROBE_NS  = 250;
	localparam int T_HOLD_NS    = 50;
	localparam int SETUP_CYC    = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_CYC   = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYC     = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W        = 4;
	localparam int FIFO_DEPTH   = 4;

	// Register select on the two address pins
	localparam logic [1:0] ADDR_CHAR  = 2'h0;
	localparam logic [1:0] ADDR_MODE  = 2'h1;
	localparam logic [1:0] ADDR_CMD   = 2'h2;
	localparam logic [1:0] ADDR_CLASS = 2'h3;

	// Mode register fields
	localparam int MR_POLY_LO   = 0;
	localparam int MR_POLY_HI   = 1;
	localparam int MR_DIR       = 2;
	localparam int MR_HPE       = 3;
	localparam int MR_PAR_EN    = 4;
	localparam int MR_ACC_LO    = 6;
	localparam int MR_ACC_HI    = 7;
	localparam logic [1:0] POLY_NONE  = 2'h0;
	localparam logic [1:0] POLY_CRC16 = 2'h1;
	localparam logic [1:0] POLY_CRC12 = 2'h2;
	localparam logic [1:0] POLY_LRC8  = 2'h3;
	localparam logic [1:0] ACC_NORMAL = 2'h0;
	localparam logic [1:0] ACC_TRANSP = 2'h1;
	localparam logic [1:0] ACC_AUTO   = 2'h2;
	localparam logic [1:0] ACC_SINGLE = 2'h3;

	// Command register fields
	localparam int CR_CTL_LO    = 0;
	localparam int CR_CTL_HI    = 1;
	localparam logic [1:0] CTL_NOP    = 2'h0;
	localparam logic [1:0] CTL_START  = 2'h1;
	localparam logic [1:0] CTL_CLEAR  = 2'h2;
	localparam logic [1:0] CTL_MRESET = 2'h3;

	localparam int CHAR_BIT6    = 6;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef enum logic [2:0] {
		OP_MODE      = 3'h0,
		OP_CMD       = 3'h1,
		OP_CLASS     = 3'h2,
		OP_CHAR      = 3'h3,
		OP_DIRECT    = 3'h4,
		OP_RD_STATUS = 3'h5,
		OP_RD_BCC    = 3'h6,
		OP_RESTART   = 3'h7
	} bcp_op_e;

	typedef struct packed {
		bcp_op_e    op;
		logic [7:0] data;
	} bcp_req_s;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SETUP  = 2'b01,
		ST_STROBE = 2'b11,
		ST_HOLD   = 2'b10
	} bcp_state_e;
endpackage

// [rtl/bcp_fifo.sv]
// Request FIFO with valid/ready on both sides
`timescale 1ns/1ps
module bcp_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	wire              push = in_valid_i && in_ready_o;
	wire              pop  = out_valid_o && out_ready_i;

	assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o  = mem_reg[rd_reg];

	always_ff @(posedge clk_i) begin
		if (push)
			mem_reg[wr_reg] <= in_data_i;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push)
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// [rtl/bcp_host_ctrl.sv]
// Host-side controller driving the block-check device pins from a queued request port
// Overview of operation
// - Poly bits nonzero only after class programming
// - CRC-12 class entries written with bit6 clear
// - Keep parity off for transparent or CRC-12
// - False terminator restarted by start command
// - Character load pattern follows direction bit
`timescale 1ns/1ps
module bcp_host_ctrl (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// User side
	input  wire logic             req_valid_i,
	output logic                  req_ready_o,
	input  wire bcp_pkg::bcp_req_s req_i,
	input  wire logic             cfg_crc12_i,
	input  wire logic             cfg_8bit_code_i,
	output logic                  rsp_valid_o,
	output logic [7:0]            rsp_data_o,
	output logic                  rsp_err_o,
	output logic                  busy_o,
	// Device pins
	output logic [1:0]            addr_o,
	output logic                  rd_wr_o,
	output logic                  monitor_strobe_n_o,
	output logic                  host_strobe_n_o,
	output logic [7:0]            data_o,
	output logic                  data_oe_n_o,
	input  wire logic [7:0]       data_i
);
	import bcp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	bcp_req_s      head;
	logic          head_valid;
	logic          head_pop;
	bcp_state_e    state_reg;
	logic [CNT_W-1:0] cnt_reg;
	bcp_req_s      cur_reg;
	logic [7:0]    mode_reg;
	logic [7:0]    cmd_reg;
	logic [1:0]    addr_reg;
	logic          rw_reg;
	logic          mon_reg;
	logic [7:0]    dout_reg;
	logic          drive_reg;

	bcp_fifo #(
		.WIDTH($bits(bcp_req_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.in_valid_i (req_valid_i),
		.in_ready_o (req_ready_o),
		.in_data_i  (req_i),
		.out_valid_o(head_valid),
		.out_ready_i(head_pop),
		.out_data_o (head)
	);

	////////////////////////////////////////////////////////////////////////////
	// Decode of the request at the FIFO head
	wire        idle      = (state_reg == ST_IDLE);
	wire        poly_zero = (mode_reg[MR_POLY_HI:MR_POLY_LO] == POLY_NONE);
	wire        refuse    = (head.op == OP_CLASS) && !poly_zero;
	wire [1:0]  new_poly  = head.data[MR_POLY_HI:MR_POLY_LO];
	wire [1:0]  new_acc   = head.data[MR_ACC_HI:MR_ACC_LO];
	// Parity would corrupt six-bit and transparent traffic
	wire        par_off   = (new_poly == POLY_CRC12) || (new_acc == ACC_TRANSP)
	                        || ((new_poly == POLY_CRC16) && cfg_8bit_code_i);
	wire [7:0]  mode_wr   = par_off ? (head.data & ~(8'h01 << MR_PAR_EN)) : head.data;
	wire [7:0]  class_wr  = cfg_crc12_i ? (head.data & ~(8'h01 << CHAR_BIT6)) : head.data;
	wire [7:0]  start_wr  = {cmd_reg[7:CR_CTL_HI+1], CTL_START};
	wire        is_read   = (head.op == OP_RD_STATUS) || (head.op == OP_RD_BCC);
	wire        dir_tx    = mode_reg[MR_DIR];
	wire        mon_cycle = (head.op == OP_CHAR);
	// Monitor path follows the direction bit: write when sending, read pattern when receiving
	wire        rw_next   = mon_cycle ? dir_tx : !is_read;
	logic [1:0] addr_next;
	logic [7:0] dout_next;

	always_comb begin
		addr_next = ADDR_CHAR;
		dout_next = head.data;
		unique case (head.op)
			OP_MODE:      begin addr_next = ADDR_MODE;  dout_next = mode_wr;  end
			OP_CMD:       begin addr_next = ADDR_CMD;   dout_next = head.data; end
			OP_CLASS:     begin addr_next = ADDR_CLASS; dout_next = class_wr; end
			OP_CHAR:      begin addr_next = ADDR_CHAR;  dout_next = head.data; end
			OP_DIRECT:    begin addr_next = ADDR_CHAR;  dout_next = head.data; end
			OP_RD_STATUS: begin addr_next = ADDR_CMD;   dout_next = BYTE_ZERO; end
			OP_RD_BCC:    begin addr_next = ADDR_CLASS; dout_next = BYTE_ZERO; end
			OP_RESTART:   begin addr_next = ADDR_CMD;   dout_next = start_wr; end
		endcase
	end

	assign head_pop = idle && head_valid;

	////////////////////////////////////////////////////////////////////////////
	// Pin cycle sequencer
	wire last_setup  = (state_reg == ST_SETUP)  && (cnt_reg == CNT_W'(SETUP_CYC - 1));
	wire last_strobe = (state_reg == ST_STROBE) && (cnt_reg == CNT_W'(STROBE_CYC - 1));
	wire last_hold   = (state_reg == ST_HOLD)   && (cnt_reg == CNT_W'(HOLD_CYC - 1));
	wire wr_done     = last_hold && rw_reg && !mon_reg;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= '0;
		end else begin
			cnt_reg <= (last_setup || last_strobe || last_hold || idle) ? '0 : cnt_reg + 1'b1;
			unique case (state_reg)
				ST_IDLE:   if (head_pop && !refuse) state_reg <= ST_SETUP;
				ST_SETUP:  if (last_setup) state_reg <= ST_STROBE;
				ST_STROBE: if (last_strobe) state_reg <= ST_HOLD;
				ST_HOLD:   if (last_hold) state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cur_reg   <= '0;
			addr_reg  <= ADDR_CHAR;
			rw_reg    <= 1'b0;
			mon_reg   <= 1'b0;
			dout_reg  <= BYTE_ZERO;
			drive_reg <= 1'b0;
		end else if (head_pop && !refuse) begin
			cur_reg   <= head;
			addr_reg  <= addr_next;
			rw_reg    <= rw_next;
			mon_reg   <= mon_cycle;
			dout_reg  <= dout_next;
			drive_reg <= !is_read;
		end
	end

	// Shadows of what was written to the device
	wire [1:0] cur_ctl = cur_reg.data[CR_CTL_HI:CR_CTL_LO];
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mode_reg <= BYTE_ZERO;
			cmd_reg  <= BYTE_ZERO;
		end else if (wr_done) begin
			if (cur_reg.op == OP_MODE)
				mode_reg <= dout_reg;
			if (cur_reg.op == OP_CMD && cur_ctl == CTL_MRESET) begin
				mode_reg <= BYTE_ZERO;
				cmd_reg  <= BYTE_ZERO;
			end else if (cur_reg.op == OP_CMD) begin
				cmd_reg <= {cur_reg.data[7:CR_CTL_HI+1], CTL_NOP};
			end
		end
	end

	// Answer: read data is taken in the last strobe-low cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rsp_valid_o <= 1'b0;
			rsp_data_o  <= BYTE_ZERO;
			rsp_err_o   <= 1'b0;
		end else begin
			rsp_valid_o <= last_hold || (head_pop && refuse);
			rsp_err_o   <= head_pop && refuse;
			if (last_strobe && !rw_reg)
				rsp_data_o <= data_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	wire strobing = (state_reg == ST_STROBE);
	assign busy_o             = !idle;
	assign addr_o             = addr_reg;
	assign rd_wr_o            = rw_reg;
	assign monitor_strobe_n_o = !(strobing && mon_reg);
	assign host_strobe_n_o    = !(strobing && !mon_reg);
	assign data_o             = dout_reg;
	assign data_oe_n_o        = idle || !drive_reg;

	////////////////////////////////////////////////////////////////////////////
	property p_class_poly_zero;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!host_strobe_n_o && addr_o == ADDR_CLASS && rd_wr_o) |-> poly_zero;
	endproperty
	a_class_poly_zero: assert property (p_class_poly_zero) else $error("class write with poly set");

	property p_class_bit6;
		@(posedge clk_i) disable iff (!rst_n_i)
		(head_pop && head.op == OP_CLASS && !refuse && cfg_crc12_i) |=> ##(SETUP_CYC) (!data_o[CHAR_BIT6] && !host_strobe_n_o);
	endproperty
	a_class_bit6: assert property (p_class_bit6) else $error("class entry bit6 not cleared");

	property p_parity_off;
		@(posedge clk_i) disable iff (!rst_n_i)
		(head_pop && head.op == OP_MODE && new_poly == POLY_CRC12) |=> ##(SETUP_CYC) (!data_o[MR_PAR_EN] && addr_o == ADDR_MODE);
	endproperty
	a_parity_off: assert property (p_parity_off) else $error("parity left on for crc12");

	property p_restart;
		@(posedge clk_i) disable iff (!rst_n_i)
		(head_pop && head.op == OP_RESTART) |=> ##(SETUP_CYC)
			(!host_strobe_n_o && addr_o == ADDR_CMD && data_o[CR_CTL_HI:CR_CTL_LO] == CTL_START && rd_wr_o);
	endproperty
	a_restart: assert property (p_restart) else $error("restart did not issue start command");

	property p_char_load;
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(monitor_strobe_n_o) |-> (addr_o == ADDR_CHAR && host_strobe_n_o && rd_wr_o == mode_reg[MR_DIR])
			##1 (!monitor_strobe_n_o && $stable(addr_o));
	endproperty
	a_char_load: assert property (p_char_load) else $error("bad character load pattern");
endmodule

// [verif/bcp_dev_model.sv]
// Behavioural model of the block-check device seen from its pins
`timescale 1ns/1ps
module bcp_dev_model
	import bcp_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic [1:0] addr_i,
	input  wire logic       rd_wr_i,
	input  wire logic       mon_n_i,
	input  wire logic       host_n_i,
	input  wire logic [7:0] bus_i,
	output logic      [7:0] drv_o
);
	logic [7:0] mode_reg = 8'h00;
	logic [7:0] cmd_reg  = 8'h00;
	logic [7:0] stat_reg = 8'h00;
	logic [7:0] bcc_reg  = 8'h00;
	logic [7:0] cls_reg  = 8'h00;
	logic [7:0] last_reg = 8'h00;
	logic       hs_q     = 1'b1;
	logic       ms_q     = 1'b1;
	logic [1:0] cls_code_reg = 2'b00;
	logic       esc_odd_reg  = 1'b0;
	logic       stop_reg     = 1'b0;
	logic [1:0] tail_reg     = 2'b00;
	wire        host_rise = host_n_i & ~hs_q;
	wire        rd_sel    = ~host_n_i & ~rd_wr_i;
	wire        ld_mon    = mon_n_i & ~ms_q & (addr_i == 2'h0) & (rd_wr_i == mode_reg[2]);
	wire        ld_host   = host_rise & rd_wr_i & (addr_i == 2'h0);
	wire        par_bit   = ^bus_i[6:0] ^ mode_reg[5];
	wire        crc12     = (mode_reg[1:0] == POLY_CRC12);
	wire        transp    = (mode_reg[7:6] == ACC_TRANSP);
	wire        ld_any    = (ld_mon | (ld_host & mode_reg[3])) & (mode_reg[1:0] != POLY_NONE);
	// One class entry is enough for the scenarios; top bit never takes part
	wire  [6:0] cls_key   = crc12 ? {1'b0, bus_i[5:0]} : bus_i[6:0];
	wire        cls_hit   = (cls_key == cls_reg[6:0]);
	wire  [7:0] esc_char  = mode_reg[4] ? {par_bit, bus_i[6:0]} : bus_i;
	wire        esc_hit   = crc12 ? (bus_i[5:0] == 6'h1F) : ((esc_char == 8'h10) | (esc_char == 8'h90));
	wire        is_sync   = cls_hit & (cls_code_reg == 2'h1);
	wire        sync_skip = is_sync & ((mode_reg[7:6] == ACC_NORMAL) | (transp & esc_odd_reg));
	wire        is_term   = cls_hit & (cls_code_reg == 2'h2) & (~transp | esc_odd_reg);
	wire        is_ssc    = cls_hit & (cls_code_reg == 2'h3) & esc_odd_reg & ~transp;
	wire        counted   = ld_any & ~stop_reg & ~sync_skip;
	wire        acc       = counted & (mode_reg[1:0] == POLY_LRC8);
	wire  [6:0] lrc_low   = bcc_reg[6:0] ^ bus_i[6:0];
	// Released bus toggles so a late sample never looks valid
	assign drv_o = (rd_sel & (addr_i == 2'h2)) ? {cmd_reg[7:4], stat_reg[3:0]} :
		(rd_sel & (addr_i == 2'h3)) ? bcc_reg : ~last_reg;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		hs_q <= host_n_i;
		ms_q <= mon_n_i;
		last_reg <= drv_o;
		if ((ld_mon | ld_host) & mode_reg[4] & (bus_i[7] != par_bit))
			stat_reg[1] <= 1'b1;
		if (acc)
			bcc_reg <= {^lrc_low ^ ~mode_reg[5], lrc_low};
		if (crc12)
			bcc_reg[7:6] <= 2'h0;
		if (acc & ~mode_reg[2] & mode_reg[7])
			stat_reg[0] <= (lrc_low != 7'h00);
		if (counted) begin
			esc_odd_reg <= esc_hit & ~esc_odd_reg;
			if (tail_reg != 2'h0) begin
				tail_reg <= tail_reg - 2'h1;
				if (tail_reg == 2'h1) begin
					stop_reg    <= 1'b1;
					stat_reg[0] <= (mode_reg[1:0] == POLY_LRC8) & (lrc_low != 7'h00);
				end
			end else if (is_term) begin
				stat_reg[2] <= 1'b1;
				if (~mode_reg[7]) begin
					if (mode_reg[2])
						stop_reg <= 1'b1;
					else
						tail_reg <= (mode_reg[1:0] == POLY_LRC8) ? 2'h1 : 2'h2;
				end
			end else if (is_ssc) begin
				stat_reg[3] <= 1'b1;
			end
		end
		if (host_rise & ~rd_wr_i & (addr_i == 2'h2))
			stat_reg[3:0] <= 4'h0;
		if (host_rise & rd_wr_i) begin
			case (addr_i)
				2'h1: begin
					mode_reg <= bus_i;
					stop_reg <= 1'b0;
					tail_reg <= 2'h0;
				end
				2'h2: begin
					cmd_reg <= bus_i;
					if (bus_i[1:0] == CTL_START)
						stop_reg <= 1'b0;
					if (bus_i[1:0] == CTL_CLEAR) begin
						bcc_reg       <= 8'h00;
						stat_reg[3:0] <= 4'h0;
						stop_reg      <= 1'b0;
						tail_reg      <= 2'h0;
					end
					if (bus_i[1:0] == CTL_MRESET) begin
						mode_reg <= 8'h00;
						cmd_reg <= 8'h00;
						stat_reg <= 8'h00;
						bcc_reg <= 8'h00;
						cls_reg <= 8'h00;
						cls_code_reg <= 2'h0;
						esc_odd_reg <= 1'b0;
						stop_reg <= 1'b0;
						tail_reg <= 2'h0;
					end
				end
				2'h3: if (mode_reg[1:0] == POLY_NONE) begin
					cls_reg      <= {1'b0, bus_i[6:0]};
					cls_code_reg <= cmd_reg[3:2];
				end
				default: ;
			endcase
		end
	end
endmodule

// [verif/bcp_host_ctrl_tb.sv]
// Self-checking bench for the block-check host controller
`timescale 1ns/1ps
module bcp_host_ctrl_tb;
	import bcp_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, crc12 = 1'b0, code8 = 1'b0;
	logic req_ready, rsp_valid, rsp_err, busy, rd_wr, mon_n, host_n, oe_n;
	logic [1:0] addr;
	logic [7:0] rsp_data, data_o, dev_drv;
	wire  [7:0] bus = oe_n ? dev_drv : data_o;
	bcp_req_s req = '0;
	int n_errors = 0, checks_done = 0, low_cnt;
	initial forever #12.5 clk = ~clk;
	bcp_host_ctrl dut (.clk_i(clk), .rst_n_i(rst_n), .req_valid_i(req_valid), .req_ready_o(req_ready),
		.req_i(req), .cfg_crc12_i(crc12), .cfg_8bit_code_i(code8), .rsp_valid_o(rsp_valid),
		.rsp_data_o(rsp_data), .rsp_err_o(rsp_err), .busy_o(busy), .addr_o(addr), .rd_wr_o(rd_wr),
		.monitor_strobe_n_o(mon_n), .host_strobe_n_o(host_n), .data_o(data_o), .data_oe_n_o(oe_n),
		.data_i(bus));
	bcp_dev_model u_dev (.clk_i(clk), .addr_i(addr), .rd_wr_i(rd_wr), .mon_n_i(mon_n),
		.host_n_i(host_n), .bus_i(bus), .drv_o(dev_drv));
	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		if (n_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded waits so a dead handshake fails a check instead of hanging the run
	task automatic do_req(input bcp_op_e op, input logic [7:0] d);
		int i;
		@(negedge clk);
		req_valid = 1'b1;
		req = {op, d};
		i = 0;
		while (req_ready !== 1'b1 && i < 100) begin @(negedge clk); i++; end
		@(negedge clk);
		req_valid = 1'b0;
		low_cnt = 0;
		i = 0;
		while (rsp_valid !== 1'b1 && i < 100) begin
			if (host_n === 1'b0 || mon_n === 1'b0) low_cnt++;
			@(negedge clk);
			i++;
		end
		chk({7'h0, rsp_valid}, 8'h01);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_class();
		crc12 = 1'b1;
		do_req(OP_CMD, 8'h03);
		do_req(OP_CLASS, 8'hFF);
		chk(u_dev.cls_reg, 8'h3F);
		chk({7'h0, rsp_err}, 8'h00);
	endtask
	task automatic t_refuse();
		do_req(OP_MODE, 8'h12);
		chk(u_dev.mode_reg, 8'h02);
		do_req(OP_CLASS, 8'h05);
		chk({7'h0, rsp_err}, 8'h01);
		chk(u_dev.cls_reg, 8'h3F);
	endtask
	task automatic t_lrc();
		crc12 = 1'b0;
		do_req(OP_CMD, 8'h03);
		do_req(OP_MODE, 8'h1F);
		do_req(OP_CHAR, 8'h41);
		do_req(OP_CHAR, 8'h03);
		do_req(OP_RD_BCC, 8'h00);
		chk(rsp_data, 8'hC2);
		chk(8'(low_cnt), 8'(STROBE_CYC));
		do_req(OP_MODE, 8'h1B);
		do_req(OP_CHAR, 8'h05);
		do_req(OP_RD_BCC, 8'h00);
		chk(rsp_data, 8'hC7);
	endtask
	task automatic t_parity();
		do_req(OP_DIRECT, 8'h01);
		do_req(OP_RD_STATUS, 8'h00);
		chk(rsp_data, 8'h02);
		do_req(OP_RD_STATUS, 8'h00);
		chk(rsp_data, 8'h00);
	endtask
	// Back-to-back pushes: one in flight plus a full queue, then refusal
	task automatic t_fifo();
		int n, cnt;
		n = 0;
		cnt = 0;
		repeat (8) begin
			@(negedge clk);
			req_valid = 1'b1;
			req = {OP_MODE, 8'(n)};
			if (req_ready === 1'b1) n++;
		end
		@(negedge clk);
		req_valid = 1'b0;
		repeat (120) begin
			@(negedge clk);
			if (rsp_valid === 1'b1) cnt++;
		end
		chk(8'(n), 8'(1 + FIFO_DEPTH));
		chk(8'(cnt), 8'(1 + FIFO_DEPTH));
		chk(u_dev.mode_reg, 8'h04);
		do_req(OP_RD_BCC, 8'h00);
		chk(rsp_data, 8'h06);
		do_req(OP_RESTART, 8'h00);
		chk(u_dev.cmd_reg, 8'h01);
	endtask
	// Terminator in transmit stops the check until a start command
	task automatic t_term();
		do_req(OP_CMD, 8'h0B);
		do_req(OP_CMD, 8'h08);
		do_req(OP_CLASS, 8'h03);
		do_req(OP_MODE, 8'h07);
		do_req(OP_CHAR, 8'h41);
		do_req(OP_CHAR, 8'h03);
		do_req(OP_CHAR, 8'h05);
		do_req(OP_RD_BCC, 8'h00);
		chk(rsp_data, 8'hC2);
		do_req(OP_RD_STATUS, 8'h00);
		chk(rsp_data, 8'h04);
		do_req(OP_RESTART, 8'h00);
		do_req(OP_CHAR, 8'h05);
		do_req(OP_RD_BCC, 8'h00);
		chk(rsp_data, 8'hC7);
	endtask
	// Eight-bit code with CRC-16 and transparent mode both force parity off
	task automatic t_code8();
		code8 = 1'b1;
		do_req(OP_MODE, 8'h11);
		chk(u_dev.mode_reg, 8'h01);
		do_req(OP_MODE, 8'h5B);
		chk(u_dev.mode_reg, 8'h4B);
		code8 = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#(20000 * 25);
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk({3'h0, host_n, mon_n, oe_n, rsp_valid, req_ready}, 8'h1D);
		t_class();
		t_refuse();
		t_lrc();
		t_parity();
		t_fifo();
		t_term();
		t_code8();
		wrap_up();
	end
endmodule
